// ---- include/dsc_consts.svh ----
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

// ----------------------------------------------------------------
// Command byte bit positions
// ----------------------------------------------------------------
`define DSC_CMD_OFF 0
`define DSC_CMD_ON 1
`define DSC_CMD_QSTOP 2
`define DSC_CMD_CLRF 3
`define DSC_CMD_PSET 5
`define DSC_CMD_PCLR 6
`define DSC_CMD_PRES 7

// ----------------------------------------------------------------
// Status word field positions
// ----------------------------------------------------------------
`define DSC_SW_ERR 6
`define DSC_SW_WARN 7
`define DSC_SW_PAUSE 8
`define DSC_SW_XINFO 13
`define DSC_SW_XEND 14
`define DSC_SW_XERR 15

// ----------------------------------------------------------------
// Mode status byte fields and reset values
// ----------------------------------------------------------------
`define DSC_MS_REFOK 5
`define DSC_MS_REJ 6
`define DSC_MS_TOG 7
`define DSC_CMD_RST 8'h00
`define DSC_MODE_RST 4'h0

`endif

// ---- include/dsc_pkg.sv ----
package dsc_pkg;

  // Operating states, binary coded as reported in the status word
  typedef enum logic [3:0] {
    DSC_ST_START = 4'h1,
    DSC_ST_NOTRDY = 4'h2,
    DSC_ST_SWDIS = 4'h3,
    DSC_ST_READY = 4'h4,
    DSC_ST_SWON = 4'h5,
    DSC_ST_OPEN = 4'h6,
    DSC_ST_QSTOP = 4'h7,
    DSC_ST_FREACT = 4'h8,
    DSC_ST_FAULT = 4'h9
  } dsc_state_t;

  // Requests decoded from the command byte and the discrete inputs
  typedef struct packed {
    logic power_off;
    logic power_on;
    logic fast_stop;
    logic clear_fault;
    logic pause_set;
    logic pause_clear;
    logic pause_resume;
  } dsc_req_t;

  // Status reported by the surrounding drive core
  typedef struct packed {
    logic err_cls123;
    logic err_cls0;
    logic err_cls23;
    logic mode_err;
    logic mode_info;
    logic mode_end;
    logic ref_ok;
  } dsc_core_t;

endpackage : dsc_pkg

// ---- rtl/dsc_edge.sv ----
`include "dsc_consts.svh"

// Rising and falling edge finder; history clears to zero at reset
module dsc_edge #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_en,
  input wire logic [W-1:0] i_val,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);

  logic [W-1:0] prev_r;

  assign o_rise = i_en ? (i_val & ~prev_r) : '0;
  assign o_fall = i_en ? (~i_val & prev_r) : '0;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_r <= '0;
    end else if (i_en) begin
      prev_r <= i_val;
    end
  end

endmodule : dsc_edge

// ---- rtl/dsc_mode_stat.sv ----
`include "dsc_consts.svh"

// Mode status byte: selected mode, zero point, reject flag, toggle echo
module dsc_mode_stat (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_mode_done,
  input wire logic [3:0] i_mode_sel,
  input wire logic i_mode_tog,
  input wire logic i_mode_rej,
  input wire logic i_ref_ok,
  output logic [7:0] o_mode_status_byte
);

  logic [3:0] mode_r;
  logic rej_r;
  logic tog_r;
  logic refok_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_r <= `DSC_MODE_RST;
      rej_r <= 1'b0;
      tog_r <= 1'b0;
      refok_r <= 1'b0;
    end else if (i_ce) begin
      refok_r <= i_ref_ok;
      if (i_mode_done) begin
        mode_r <= i_mode_sel;
        rej_r <= i_mode_rej;
        tog_r <= i_mode_tog;
      end
    end
  end

  always_comb begin
    o_mode_status_byte = 8'h00;
    o_mode_status_byte[3:0] = mode_r;
    o_mode_status_byte[`DSC_MS_REFOK] = refok_r;
    o_mode_status_byte[`DSC_MS_REJ] = rej_r;
    o_mode_status_byte[`DSC_MS_TOG] = tog_r;
  end

endmodule : dsc_mode_stat

// ---- rtl/dsc_top.sv ----
`include "dsc_consts.svh"

// Function
// - Healthy in 4-6, power live only 6
// - Status bits 0-3 carry state code
// - Status bit 6 flags class 1-3 error
// - Status bit 7 flags class 0 warning
// - Bits 13-15 carry mode info, end, error
// - Mode end bit 0 started, 1 done
// - Power input edges enable or disable stage
// - Fault clear input rise resets fault
// - Command bits move states as mapped
// - Pause set, clear, resume in state 6
// - Command bits act on 0-to-1; bit 1 level also gates fault clear
// - Impossible requests dropped silently
// - All-zero command write disables stage
// - Disable beats enable
// - Fast stop beats bit 3 fault clear, not the fault clear input rise
// - Pause set beats clear and resume
// - Fault clear after class 2/3 needs bit1=0
// - Mode byte bits 0-3 report mode
// - Mode byte bit 5 zero point valid
// - Mode byte bit 6 request rejected
// - Enable goes 4 to 5 then 6
module dsc_top (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_cmd_data,
  input wire logic i_power_stage_in,
  input wire logic i_fault_clear_in,
  input wire logic i_init_done,
  input wire logic i_param_done,
  input wire logic i_ready_ok,
  input wire logic i_err_cls1,
  input wire logic i_err_cls234,
  input wire logic i_fault_react_done,
  input wire logic i_err_cls34,
  input wire dsc_pkg::dsc_core_t i_core,
  input wire logic i_mode_done,
  input wire logic [3:0] i_mode_sel,
  input wire logic i_mode_tog,
  input wire logic i_mode_rej,
  output logic [7:0] o_drive_command_byte,
  output logic [15:0] o_drive_status_word,
  output logic [7:0] o_mode_status_byte,
  output logic o_healthy_out,
  output logic o_power_live_out,
  output logic o_pause_active
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dsc_pkg::dsc_state_t state_r;
  dsc_pkg::dsc_state_t state_nxt;
  logic [7:0] cmd_r;
  logic pause_r;
  logic pause_nxt;
  logic cls23_r;
  logic cls23_nxt;
  logic healthy_r;
  logic live_r;
  logic [15:0] status_r;
  logic [15:0] status_nxt;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic [7:0] cmd_rise;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  logic [1:0] pins;

  assign pins = {i_fault_clear_in, i_power_stage_in};

  dsc_edge #(.W(8)) u_cmd_edge (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_en(i_ce & i_cmd_wr),
    .i_val(i_cmd_data),
    .o_rise(cmd_rise),
    .o_fall()
  );

  dsc_edge #(.W(2)) u_pin_edge (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_en(i_ce),
    .i_val(pins),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  // ----------------------------------------------------------------
  // Request decode with priorities
  // ----------------------------------------------------------------
  dsc_pkg::dsc_req_t req;
  wire all_zero_wr = i_ce & i_cmd_wr & (i_cmd_data == 8'h00);
  wire off_any = cmd_rise[`DSC_CMD_OFF] | all_zero_wr;
  wire qs_bit = cmd_rise[`DSC_CMD_QSTOP];
  wire ps_bit = cmd_rise[`DSC_CMD_PSET];
  // Bit 1 as last written gates fault clear after heavy errors
  wire on_held = i_cmd_wr ? i_cmd_data[`DSC_CMD_ON] : cmd_r[`DSC_CMD_ON];
  wire clr_raw = (cmd_rise[`DSC_CMD_CLRF] & ~qs_bit) | pin_rise[1];
  wire clr_ok = ~(cls23_r & on_held);

  assign req.power_off = off_any | pin_fall[0];
  assign req.power_on = (cmd_rise[`DSC_CMD_ON] | pin_rise[0])
    & ~req.power_off;
  assign req.fast_stop = qs_bit;
  assign req.clear_fault = clr_raw & clr_ok;
  assign req.pause_set = ps_bit;
  assign req.pause_clear = cmd_rise[`DSC_CMD_PCLR] & ~ps_bit;
  assign req.pause_resume = cmd_rise[`DSC_CMD_PRES] & ~ps_bit;

  // ----------------------------------------------------------------
  // Operating state machine
  // ----------------------------------------------------------------
  // Requests that do not fit the current state fall through to the
  // default hold, with no error raised.
  always_comb begin
    state_nxt = state_r;
    pause_nxt = pause_r;
    cls23_nxt = cls23_r;
    if (i_err_cls234 && state_r != dsc_pkg::DSC_ST_FREACT &&
        state_r != dsc_pkg::DSC_ST_FAULT) begin
      state_nxt = dsc_pkg::DSC_ST_FREACT;
      cls23_nxt = 1'b1;
    end else begin
      case (state_r)
        dsc_pkg::DSC_ST_START: begin
          if (i_init_done) begin
            state_nxt = dsc_pkg::DSC_ST_NOTRDY;
          end
        end
        dsc_pkg::DSC_ST_NOTRDY: begin
          if (i_param_done) begin
            state_nxt = dsc_pkg::DSC_ST_SWDIS;
          end
        end
        dsc_pkg::DSC_ST_SWDIS: begin
          if (i_ready_ok) begin
            state_nxt = dsc_pkg::DSC_ST_READY;
          end
        end
        dsc_pkg::DSC_ST_READY: begin
          if (!i_ready_ok) begin
            state_nxt = dsc_pkg::DSC_ST_SWDIS;
          end else if (req.power_on) begin
            state_nxt = dsc_pkg::DSC_ST_SWON;
          end
        end
        dsc_pkg::DSC_ST_SWON: begin
          if (req.power_off) begin
            state_nxt = dsc_pkg::DSC_ST_SWDIS;
          end else begin
            state_nxt = dsc_pkg::DSC_ST_OPEN;
          end
        end
        dsc_pkg::DSC_ST_OPEN: begin
          if (cmd_rise[`DSC_CMD_OFF]) begin
            state_nxt = dsc_pkg::DSC_ST_READY;
            pause_nxt = 1'b0;
          end else if (req.power_off) begin
            state_nxt = dsc_pkg::DSC_ST_SWDIS;
            pause_nxt = 1'b0;
          end else if (req.fast_stop || i_err_cls1) begin
            state_nxt = dsc_pkg::DSC_ST_QSTOP;
          end else if (req.pause_set) begin
            pause_nxt = 1'b1;
          end else if (req.pause_clear || req.pause_resume) begin
            pause_nxt = 1'b0;
          end
        end
        dsc_pkg::DSC_ST_QSTOP: begin
          if (req.power_off) begin
            state_nxt = dsc_pkg::DSC_ST_SWDIS;
          end else if (req.clear_fault) begin
            state_nxt = dsc_pkg::DSC_ST_OPEN;
          end
        end
        dsc_pkg::DSC_ST_FREACT: begin
          if (i_fault_react_done || i_err_cls34) begin
            state_nxt = dsc_pkg::DSC_ST_FAULT;
          end
        end
        dsc_pkg::DSC_ST_FAULT: begin
          if (req.clear_fault) begin
            state_nxt = dsc_pkg::DSC_ST_READY;
            cls23_nxt = 1'b0;
          end
        end
        default: begin
          state_nxt = dsc_pkg::DSC_ST_START;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status assembly
  // ----------------------------------------------------------------
  always_comb begin
    status_nxt = 16'h0000;
    status_nxt[3:0] = state_nxt;
    status_nxt[`DSC_SW_ERR] = i_core.err_cls123;
    status_nxt[`DSC_SW_WARN] = i_core.err_cls0;
    status_nxt[`DSC_SW_PAUSE] = pause_nxt;
    status_nxt[`DSC_SW_XINFO] = i_core.mode_info;
    status_nxt[`DSC_SW_XEND] = i_core.mode_end;
    status_nxt[`DSC_SW_XERR] = i_core.mode_err;
  end

  wire healthy_nxt = (state_nxt == dsc_pkg::DSC_ST_READY) ||
    (state_nxt == dsc_pkg::DSC_ST_SWON) ||
    (state_nxt == dsc_pkg::DSC_ST_OPEN);
  wire live_nxt = (state_nxt == dsc_pkg::DSC_ST_OPEN);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= dsc_pkg::DSC_ST_START;
      cmd_r <= `DSC_CMD_RST;
      pause_r <= 1'b0;
      cls23_r <= 1'b0;
      status_r <= 16'h0001;
      healthy_r <= 1'b0;
      live_r <= 1'b0;
    end else if (i_ce) begin
      state_r <= state_nxt;
      pause_r <= pause_nxt;
      cls23_r <= cls23_nxt;
      status_r <= status_nxt;
      healthy_r <= healthy_nxt;
      live_r <= live_nxt;
      if (i_cmd_wr) begin
        cmd_r <= i_cmd_data;
      end
    end
  end

  dsc_mode_stat u_mode_stat (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_mode_done(i_mode_done),
    .i_mode_sel(i_mode_sel),
    .i_mode_tog(i_mode_tog),
    .i_mode_rej(i_mode_rej),
    .i_ref_ok(i_core.ref_ok),
    .o_mode_status_byte(o_mode_status_byte)
  );

  assign o_drive_command_byte = cmd_r;
  assign o_drive_status_word = status_r;
  assign o_healthy_out = healthy_r;
  assign o_power_live_out = live_r;
  assign o_pause_active = pause_r;

endmodule : dsc_top

// ---- test/dsc_top_chk.sv ----
module dsc_top_chk (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_cmd_data,
  input wire logic i_ready_ok,
  input wire logic i_err_cls234,
  input wire dsc_pkg::dsc_core_t i_core,
  input wire logic i_mode_done,
  input wire logic [3:0] i_mode_sel,
  input wire logic i_mode_tog,
  input wire logic i_mode_rej,
  input wire logic [7:0] o_drive_command_byte,
  input wire logic [15:0] o_drive_status_word,
  input wire logic [7:0] o_mode_status_byte,
  input wire logic o_healthy_out,
  input wire logic o_power_live_out,
  input wire logic o_pause_active
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic [3:0] st;
  logic wr;
  logic [7:0] rise;
  assign st = o_drive_status_word[3:0];
  // Heavy errors override every command outside states 8 and 9, so they are kept out
  assign wr = i_ce && i_cmd_wr && !i_err_cls234;
  assign rise = i_cmd_data & ~o_drive_command_byte;

  healthy_out_a: assert property (
    o_healthy_out == (st inside {4'h4, 4'h5, 4'h6}))
    else $error("healthy output wrong");
  power_live_a: assert property (
    o_power_live_out == (st == 4'h6)) else $error("live output wrong");
  state_field_a: assert property (
    o_drive_status_word[5:4] == 2'h0 && o_drive_status_word[12:9] == 4'h0
    && st inside {[4'h1:4'h9]}) else $error("status field wrong");
  error_flags_a: assert property (
    i_ce |=> o_drive_status_word[7:6] ==
      $past({i_core.err_cls0, i_core.err_cls123}))
    else $error("error flags wrong");
  mode_flags_a: assert property (
    i_ce |=> o_drive_status_word[15:13] ==
      $past({i_core.mode_err, i_core.mode_end, i_core.mode_info}))
    else $error("mode flags wrong");
  cmd_store_a: assert property (
    i_ce && i_cmd_wr |=> o_drive_command_byte == $past(i_cmd_data))
    else $error("command byte wrong");
  enable_seq_a: assert property (
    wr && rise[1] && !i_cmd_data[0] && st == 4'h4 && i_ready_ok
    |=> st == 4'h5 ##1 st == 4'h6) else $error("enable sequence wrong");
  disable_cmd_a: assert property (
    wr && rise[0] && st == 4'h6 |=> st == 4'h4)
    else $error("disable request lost");
  zero_write_a: assert property (
    wr && i_cmd_data == 8'h00 && st inside {4'h5, 4'h6, 4'h7}
    |=> st == 4'h3) else $error("zero write kept stage on");
  fast_stop_a: assert property (
    wr && rise[2] && !rise[0] && st == 4'h6 |=> st == 4'h7)
    else $error("fast stop lost");
  mode_echo_a: assert property (
    i_ce && i_mode_done |=> o_mode_status_byte[3:0] == $past(i_mode_sel)
    && o_mode_status_byte[7:6] == $past({i_mode_tog, i_mode_rej}))
    else $error("mode byte wrong");
  ref_ok_a: assert property (
    i_ce |=> o_mode_status_byte[5] == $past(i_core.ref_ok)
    && !o_mode_status_byte[4]) else $error("zero point flag wrong");
  cover property (st == 4'h6 && o_pause_active);
  cover property (st == 4'h9);
  cover property (wr && rise[1]);
endmodule : dsc_top_chk

bind dsc_top dsc_top_chk chk (.*);

// ---- test/dsc_master_model.sv ----
module dsc_master_model (
  input wire logic i_clk,
  output logic o_cmd_wr,
  output logic [7:0] o_cmd_data,
  output logic o_power,
  output logic o_fclr,
  output logic o_mode_done,
  output logic [3:0] o_mode_sel,
  output logic o_mode_tog,
  output logic o_mode_rej
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {o_cmd_wr, o_cmd_data, o_power, o_fclr} = '0;
    {o_mode_done, o_mode_sel, o_mode_tog, o_mode_rej} = '0;
  end
  task automatic write_cmd(input logic [7:0] d);
    @(negedge i_clk);
    o_cmd_wr = 1'b1;
    o_cmd_data = d;
    @(negedge i_clk);
    o_cmd_wr = 1'b0;
    // Data is not held past the strobe
    o_cmd_data = ~d;
  endtask : write_cmd
  task automatic set_pins(input logic pwr, input logic fclr);
    @(negedge i_clk);
    o_power = pwr;
    o_fclr = fclr;
  endtask : set_pins
  task automatic mode_req(input logic [3:0] sel, input logic rej);
    @(negedge i_clk);
    o_mode_done = 1'b1;
    o_mode_sel = sel;
    o_mode_rej = rej;
    o_mode_tog = ~o_mode_tog;
    @(negedge i_clk);
    o_mode_done = 1'b0;
    o_mode_sel = ~sel;
  endtask : mode_req
endmodule : dsc_master_model

// ---- test/test_drive_state_control_status.sv ----
module test_drive_state_control_status;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rstn = 1'b0, rdy = 1'b0, e234 = 1'b0, react = 1'b0;
  logic ce = 1'b1, init_ok = 1'b0, param_ok = 1'b0, e1 = 1'b0, e34 = 1'b0;
  logic wr, pwr, fclr, mdone, mtog, mrej, healthy, live, pause;
  logic [7:0] cdata, cmd, msb;
  logic [3:0] msel;
  logic [15:0] sw;
  dsc_pkg::dsc_core_t core = '0;
  int num_errors = 0, n_tests = 0, cycles = 0;
  logic [7:0] pw [9] = '{8'h22, 8'h42, 8'hE2, 8'h02, 8'h62, 8'h02, 8'h42,
    8'h22, 8'h82};
  logic [8:0] pe = 9'b010111101;
  logic [3:0] codes [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
  always #12.5 clk = ~clk;
  dsc_master_model m (.i_clk(clk), .o_cmd_wr(wr), .o_cmd_data(cdata),
    .o_power(pwr), .o_fclr(fclr), .o_mode_done(mdone), .o_mode_sel(msel),
    .o_mode_tog(mtog), .o_mode_rej(mrej));
  dsc_top dut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_cmd_wr(wr),
    .i_cmd_data(cdata), .i_power_stage_in(pwr), .i_fault_clear_in(fclr),
    .i_init_done(init_ok), .i_param_done(param_ok), .i_ready_ok(rdy),
    .i_err_cls1(e1), .i_err_cls234(e234), .i_fault_react_done(react),
    .i_err_cls34(e34), .i_core(core), .i_mode_done(mdone),
    .i_mode_sel(msel), .i_mode_tog(mtog), .i_mode_rej(mrej),
    .o_drive_command_byte(cmd), .o_drive_status_word(sw),
    .o_mode_status_byte(msb), .o_healthy_out(healthy),
    .o_power_live_out(live), .o_pause_active(pause));
  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic st(input logic [3:0] e);
    chk("state", {12'h0, e}, {12'h0, sw[3:0]});
  endtask : st
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    chk("status", 16'h0001, sw);
    chk("mode byte", 16'h0000, {8'h0, msb});
    chk("command", 16'h0000, {8'h0, cmd});
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    st(4'h1);
    init_ok = 1'b1;
    @(negedge clk);
    st(4'h2);
    param_ok = 1'b1;
    @(negedge clk);
    st(4'h3);
    chk("healthy", 16'h0, {15'h0, healthy});
    rdy = 1'b1;
    @(negedge clk);
    st(4'h4);
    chk("healthy", 16'h1, {15'h0, healthy});
    chk("live", 16'h0, {15'h0, live});
    // Losing the ready condition drops back to switch-on disabled
    rdy = 1'b0;
    @(negedge clk);
    st(4'h3);
    rdy = 1'b1;
    @(negedge clk);
    st(4'h4);
    m.write_cmd(8'h04);
    st(4'h4);
    m.write_cmd(8'h00);
    m.write_cmd(8'h03);
    st(4'h4);
    m.write_cmd(8'h00);
    m.write_cmd(8'h02);
    st(4'h5);
    @(negedge clk);
    st(4'h6);
    chk("live", 16'h1, {15'h0, live});
    // A write while the clock enable is low must leave no trace
    ce = 1'b0;
    m.write_cmd(8'h01);
    ce = 1'b1;
    st(4'h6);
    chk("command", 16'h0002, {8'h0, cmd});
    m.write_cmd(8'h03);
    st(4'h4);
    m.write_cmd(8'h02);
    @(negedge clk);
    st(4'h4);
    m.write_cmd(8'h00);
    m.write_cmd(8'h02);
    @(negedge clk);
    st(4'h6);
    m.write_cmd(8'h06);
    st(4'h7);
    m.write_cmd(8'h0A);
    st(4'h6);
    m.write_cmd(8'h02);
    m.write_cmd(8'h0E);
    st(4'h7);
    m.write_cmd(8'h00);
    st(4'h3);
    repeat (2) @(negedge clk);
    m.set_pins(1'b1, 1'b0);
    repeat (3) @(negedge clk);
    st(4'h6);
    m.set_pins(1'b0, 1'b0);
    @(negedge clk);
    st(4'h3);
    repeat (2) @(negedge clk);
    m.write_cmd(8'h02);
    @(negedge clk);
    st(4'h6);
    for (int i = 0; i < 9; i++) begin
      m.write_cmd(pw[i]);
      chk("pause", {15'h0, pe[i]}, {15'h0, pause});
      chk("halt bit", {15'h0, pe[i]}, {15'h0, sw[8]});
    end
    e1 = 1'b1;
    @(negedge clk);
    e1 = 1'b0;
    st(4'h7);
    m.set_pins(1'b0, 1'b1);
    @(negedge clk);
    st(4'h6);
    m.set_pins(1'b0, 1'b0);
    e234 = 1'b1;
    @(negedge clk);
    e234 = 1'b0;
    st(4'h8);
    react = 1'b1;
    @(negedge clk);
    react = 1'b0;
    st(4'h9);
    m.set_pins(1'b0, 1'b1);
    repeat (3) @(negedge clk);
    st(4'h9);
    m.set_pins(1'b0, 1'b0);
    m.write_cmd(8'h40);
    m.set_pins(1'b0, 1'b1);
    repeat (3) @(negedge clk);
    st(4'h4);
    m.set_pins(1'b0, 1'b0);
    // Flags set first, then cleared, so later mode checks see no zero point
    for (int i = 1; i >= 0; i--) begin
      core = i ? '1 : '0;
      repeat (2) @(negedge clk);
      chk("flags", i ? 16'hE0C0 : 16'h0,
        sw & 16'hE0C0);
      chk("zero point", {15'h0, i[0]}, {15'h0, msb[5]});
    end
    e234 = 1'b1;
    @(negedge clk);
    e234 = 1'b0;
    e34 = 1'b1;
    @(negedge clk);
    e34 = 1'b0;
    st(4'h9);
    chk("healthy", 16'h0, {15'h0, healthy});
    m.write_cmd(8'h0A);
    st(4'h9);
    m.write_cmd(8'h00);
    m.write_cmd(8'h08);
    st(4'h4);
    for (int i = 0; i < 5; i++) begin
      m.mode_req(codes[i], i == 4);
      chk("mode", {8'h0, ~i[0], i == 4, 2'h0, codes[i]},
        {8'h0, msb});
    end
    summarize();
  end
endmodule : test_drive_state_control_status
